// ==== hdl/virt_dec_pkg.sv ====
package virt_dec_pkg;
	localparam logic [2:0] MAJ_COL_LSB = 3'h5;
	localparam int MAJ_COL_POS = 29;
	localparam int MAJ_ROW_POS = 26;
	localparam logic [2:0] FIRST_POOL_COL = 3'h0;
	localparam logic [2:0] FIRST_POOL_ROW = 3'h0;
	localparam logic [2:0] SECOND_POOL_COL = 3'h2;
	localparam logic [2:0] SECOND_POOL_ROW = 3'h6;
	localparam int MIN_COL_POS = 3;
	localparam int MIN_ROW_POS = 0;
	localparam logic [2:0] MIN_POOL_ROW = 3'h4;
	localparam logic [2:0] EXT_MOVE_COL = 3'h6;
	localparam logic [2:0] EXT_FUNC_COL = 3'h7;
	localparam logic [2:0] SECOND_RSVD_ROW = 3'h7;
	localparam int EXT_ROW_POS = 6;
	localparam int EXT_COL_POS = 9;
	localparam int EXT_FN_POS = 12;
	localparam logic [2:0] TLB_ROW = 3'h5;
	localparam logic [2:0] TLB_COL = 3'h0;
	localparam logic [2:0] MOVE_ROW = 3'h3;
	localparam logic [3:0] FN_PROBE = 4'h0;
	localparam logic [3:0] FN_READ = 4'h1;
	localparam logic [3:0] FN_WR_IDX = 4'h2;
	localparam logic [3:0] FN_WR_RND = 4'h3;
	localparam logic [3:0] FN_INV = 4'h4;
	localparam logic [3:0] FN_INV_FLUSH = 4'h5;
	localparam logic [3:0] FN_HYPERVISOR_CALL = 4'hc;

	typedef enum logic [12:0] {
		OP_NONE = 13'h0001,
		OP_GUEST_TLB_PROBE = 13'h0002,
		OP_GUEST_TLB_READ = 13'h0004,
		OP_GUEST_TLB_WRITE_INDEXED = 13'h0008,
		OP_GUEST_TLB_WRITE_RANDOM = 13'h0010,
		OP_GUEST_TLB_INVALIDATE = 13'h0020,
		OP_GUEST_TLB_INVALIDATE_FLUSH = 13'h0040,
		OP_HYPERVISOR_CALL = 13'h0080,
		OP_MOVE_FROM_HIGH_ROOT_CP0 = 13'h0100,
		OP_MOVE_TO_HIGH_ROOT_CP0 = 13'h0200,
		OP_MOVE_FROM_HIGH_GUEST_CP0 = 13'h0400,
		OP_MOVE_TO_HIGH_GUEST_CP0 = 13'h0800,
		OP_SECOND_POOL = 13'h1000
	} dec_op_t;

	typedef enum logic [2:0] {
		EXC_NONE = 3'h1,
		EXC_RESERVED = 3'h2,
		EXC_COP_UNUSABLE = 3'h4
	} exc_t;

	typedef enum logic [7:0] {
		CLS_PLAIN = 8'h01,
		CLS_COMPAT = 8'h02,
		CLS_PARTNER = 8'h04,
		CLS_DEBUG = 8'h08,
		CLS_MODULE = 8'h10,
		CLS_RESERVED = 8'h20,
		CLS_HIGHER = 8'h40,
		CLS_UNKNOWN = 8'h80
	} enc_class_t;

	localparam dec_op_t OP_RESET = OP_NONE;
	localparam exc_t EXC_RESET = EXC_NONE;
endpackage

// ==== hdl/enc_class_check.sv ====
`timescale 1ns/1ps
`default_nettype none
module enc_class_check
	import virt_dec_pkg::*;
(
	input wire enc_class_t enc_class,
	input wire logic is_cop,
	input wire logic cop_usable,
	input wire logic special_two,
	input wire logic kernel_mode,
	input wire logic debug_mode,
	input wire logic ops64_enabled,
	input wire logic module_present,
	input wire logic debug_insn_impl,
	output exc_t exc
);
	always_comb begin
		exc = EXC_NONE;
		case (enc_class)
			CLS_PLAIN: exc = EXC_NONE;
			CLS_COMPAT: begin
				if (kernel_mode || debug_mode || ops64_enabled) begin
					exc = EXC_NONE;
				end else if (is_cop && !cop_usable) begin
					exc = EXC_COP_UNUSABLE;
				end else begin
					exc = EXC_RESERVED;
				end
			end
			CLS_PARTNER: begin
				if (is_cop && !cop_usable && !special_two) begin
					exc = EXC_COP_UNUSABLE;
				end else begin
					exc = EXC_RESERVED;
				end
			end
			CLS_DEBUG: exc = debug_insn_impl ? EXC_NONE : EXC_RESERVED;
			CLS_MODULE: begin
				if (!module_present) begin
					exc = EXC_RESERVED;
				end else if (is_cop && !cop_usable && !kernel_mode && !debug_mode) begin
					exc = EXC_COP_UNUSABLE;
				end else begin
					exc = EXC_NONE;
				end
			end
			CLS_RESERVED: exc = EXC_RESERVED;
			CLS_HIGHER: exc = EXC_RESERVED;
			default: exc = EXC_RESERVED;
		endcase
	end
endmodule
`default_nettype wire

// ==== hdl/virt_opcode_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - compatibility-restricted encodings run in kernel, debug or 64-bit mode, else raise RI or CpU by coprocessor access.
// - partner encodings with nothing implemented raise CpU for an unusable coprocessor access outside special-two, else RI.
// - debug-support encodings raise RI when not implemented and decode exactly when implemented.
// - module-reserved encodings raise RI when the module is absent.
// - major opcode column is bits 31..29, row bits 28..26; 000/000 is first pool, 010/110 second pool.
// - first pool minor column is bits 5..3, row bits 2..0; row 100 col 110 is move pool, col 111 function pool.
// - function pool row 101 col 000 decodes bits 15..12 0000..0101 as the six guest TLB operations.
// - in that same row and column, 1100 decodes as the hypervisor call.
// - move pool row 011 decodes bits 10..9 into the four high root and guest CP0 moves; bit 11 is ignored.
// - reserved operation or field codes raise RI.
// - encodings valid only at a higher instruction-set level raise RI.
module virt_opcode_decoder
	import virt_dec_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [31:0] instr,
	input wire logic kernel_mode,
	input wire logic debug_mode,
	input wire logic ops64_enabled,
	input wire logic cp0_usable,
	input wire logic module_present,
	input wire logic wide_isa_impl,
	input wire logic debug_insn_impl,
	output logic out_valid_r,
	output dec_op_t dec_op_r,
	output exc_t exc_r
);
	function automatic logic [2:0] fld3(input logic [31:0] w, input int pos);
		fld3 = w[pos +: 3];
	endfunction

	logic [2:0] maj_col, maj_row, min_col, min_row, ext_row, ext_col;
	logic [3:0] fn;
	logic first_pool, second_pool, func_pool, move_pool;
	dec_op_t op;
	enc_class_t enc_class;
	exc_t exc;
	logic out_valid_nxt;
	dec_op_t dec_op_nxt;
	exc_t exc_nxt;

	always_comb begin
		maj_col = fld3(instr, MAJ_COL_POS);
		maj_row = fld3(instr, MAJ_ROW_POS);
		min_col = fld3(instr, MIN_COL_POS);
		min_row = fld3(instr, MIN_ROW_POS);
		ext_row = fld3(instr, EXT_ROW_POS);
		ext_col = fld3(instr, EXT_COL_POS);
		fn = instr[EXT_FN_POS +: 4];
		first_pool = (maj_col == FIRST_POOL_COL) && (maj_row == FIRST_POOL_ROW);
		second_pool = (maj_col == SECOND_POOL_COL) && (maj_row == SECOND_POOL_ROW);
		func_pool = first_pool && (min_row == MIN_POOL_ROW) && (min_col == EXT_FUNC_COL);
		move_pool = first_pool && (min_row == MIN_POOL_ROW) && (min_col == EXT_MOVE_COL);
		op = OP_NONE;
		enc_class = CLS_PLAIN;
		if (func_pool && ext_row == TLB_ROW && ext_col == TLB_COL) begin
			enc_class = CLS_MODULE;
			case (fn)
				FN_PROBE: op = OP_GUEST_TLB_PROBE;
				FN_READ: op = OP_GUEST_TLB_READ;
				FN_WR_IDX: op = OP_GUEST_TLB_WRITE_INDEXED;
				FN_WR_RND: op = OP_GUEST_TLB_WRITE_RANDOM;
				FN_INV: op = OP_GUEST_TLB_INVALIDATE;
				FN_INV_FLUSH: op = OP_GUEST_TLB_INVALIDATE_FLUSH;
				FN_HYPERVISOR_CALL: op = OP_HYPERVISOR_CALL;
				default: enc_class = CLS_RESERVED;
			endcase
		end else if (move_pool && ext_row == MOVE_ROW) begin
			enc_class = CLS_MODULE;
			case (ext_col[1:0])
				2'h0: op = OP_MOVE_FROM_HIGH_ROOT_CP0;
				2'h1: op = OP_MOVE_TO_HIGH_ROOT_CP0;
				2'h2: op = OP_MOVE_FROM_HIGH_GUEST_CP0;
				2'h3: op = OP_MOVE_TO_HIGH_GUEST_CP0;
				default: op = OP_NONE;
			endcase
		end else if (second_pool) begin
			op = OP_SECOND_POOL;
			if (!wide_isa_impl) begin
				enc_class = CLS_HIGHER;
			end else if (min_row == SECOND_RSVD_ROW) begin
				enc_class = CLS_RESERVED;
			end else begin
				enc_class = CLS_COMPAT;
			end
		end
	end

	enc_class_check u_class (
		.enc_class(enc_class),
		.is_cop(enc_class == CLS_MODULE),
		.cop_usable(cp0_usable),
		.special_two(1'b0),
		.kernel_mode(kernel_mode),
		.debug_mode(debug_mode),
		.ops64_enabled(ops64_enabled),
		.module_present(module_present),
		.debug_insn_impl(debug_insn_impl),
		.exc(exc)
	);

	always_comb begin
		out_valid_nxt = out_valid_r;
		dec_op_nxt = dec_op_r;
		exc_nxt = exc_r;
		if (!rst_n) begin
			out_valid_nxt = 1'b0;
			dec_op_nxt = OP_RESET;
			exc_nxt = EXC_RESET;
		end else if (ce) begin
			out_valid_nxt = in_valid;
			dec_op_nxt = (in_valid && exc == EXC_NONE) ? op : OP_NONE;
			exc_nxt = in_valid ? exc : EXC_NONE;
		end
	end

	always_ff @(posedge clk) begin
		out_valid_r <= out_valid_nxt;
		dec_op_r <= dec_op_nxt;
		exc_r <= exc_nxt;
	end

	// checks
	property p_compat_ok;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && second_pool && wide_isa_impl && min_row != SECOND_RSVD_ROW
			&& (kernel_mode || debug_mode || ops64_enabled))
		|=> (exc_r == EXC_NONE && dec_op_r == OP_SECOND_POOL);
	endproperty
	a_compat_ok: assert property (p_compat_ok) else $error("compat encoding trapped in privileged mode");

	property p_compat_trap;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && second_pool && wide_isa_impl && min_row != SECOND_RSVD_ROW
			&& !kernel_mode && !debug_mode && !ops64_enabled)
		|=> (exc_r == EXC_RESERVED);
	endproperty
	a_compat_trap: assert property (p_compat_trap) else $error("compat encoding not trapped");

	property p_module_absent;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && enc_class == CLS_MODULE && !module_present) |=> exc_r == EXC_RESERVED;
	endproperty
	a_module_absent: assert property (p_module_absent) else $error("absent module op not reserved");

	property p_first_pool;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && instr[31:26] != 6'h00) |=> !(dec_op_r inside {OP_GUEST_TLB_PROBE,
			OP_HYPERVISOR_CALL, OP_MOVE_TO_HIGH_GUEST_CP0});
	endproperty
	a_first_pool: assert property (p_first_pool) else $error("op decoded outside first pool");

	property p_tlb_probe;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && module_present && (kernel_mode || cp0_usable)
			&& instr[31:26] == 6'h00 && instr[5:0] == 6'h3c && instr[15:6] == 10'h005)
		|=> (dec_op_r == OP_GUEST_TLB_PROBE && exc_r == EXC_NONE);
	endproperty
	a_tlb_probe: assert property (p_tlb_probe) else $error("guest tlb probe not decoded");

	property p_hypervisor_call;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && module_present && kernel_mode
			&& instr[31:26] == 6'h00 && instr[5:0] == 6'h3c && instr[15:6] == 10'h305)
		|=> (dec_op_r == OP_HYPERVISOR_CALL);
	endproperty
	a_hypervisor_call: assert property (p_hypervisor_call) else $error("hypervisor call not decoded");

	property p_move_alias;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && module_present && kernel_mode
			&& instr[31:26] == 6'h00 && instr[5:0] == 6'h34 && instr[8:6] == 3'h3 && instr[10:9] == 2'h3)
		|=> (dec_op_r == OP_MOVE_TO_HIGH_GUEST_CP0);
	endproperty
	a_move_alias: assert property (p_move_alias) else $error("high guest move not decoded");

	property p_reserved_fn;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && instr[31:26] == 6'h00 && instr[5:0] == 6'h3c && instr[11:6] == 6'h05
			&& instr[15:12] == 4'h9)
		|=> (exc_r == EXC_RESERVED && dec_op_r == OP_NONE);
	endproperty
	a_reserved_fn: assert property (p_reserved_fn) else $error("reserved code not trapped");

	property p_higher;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && second_pool && !wide_isa_impl) |=> exc_r == EXC_RESERVED;
	endproperty
	a_higher: assert property (p_higher) else $error("higher level encoding not trapped");

	property p_one_result;
		@(posedge clk) disable iff (!rst_n)
		$onehot(dec_op_r) && $onehot(exc_r) && (exc_r == EXC_NONE || dec_op_r == OP_NONE);
	endproperty
	a_one_result: assert property (p_one_result) else $error("more than one decode result");

	property p_freeze;
		@(posedge clk) disable iff (!rst_n)
		!ce |=> $stable(dec_op_r) && $stable(exc_r) && $stable(out_valid_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with enable low");

	property p_reset_vals;
		@(posedge clk)
		!rst_n |=> (!out_valid_r && dec_op_r == OP_RESET && exc_r == EXC_RESET);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");

	property p_idle;
		@(posedge clk) disable iff (!rst_n)
		(ce && !in_valid) |=> (!out_valid_r && dec_op_r == OP_NONE && exc_r == EXC_NONE);
	endproperty
	a_idle: assert property (p_idle) else $error("result shown for an empty slot");

	property p_move_root;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && module_present && kernel_mode
			&& instr[31:26] == 6'h00 && instr[5:0] == 6'h34 && instr[11:6] == 6'h23)
		|=> (dec_op_r == OP_MOVE_FROM_HIGH_ROOT_CP0 && exc_r == EXC_NONE);
	endproperty
	a_move_root: assert property (p_move_root) else $error("aliased high root move not decoded");

	c_tlb: cover property (@(posedge clk) disable iff (!rst_n) dec_op_r == OP_GUEST_TLB_INVALIDATE_FLUSH);
	c_hyp: cover property (@(posedge clk) disable iff (!rst_n) dec_op_r == OP_HYPERVISOR_CALL);
	c_cpu: cover property (@(posedge clk) disable iff (!rst_n) exc_r == EXC_COP_UNUSABLE);
	c_move: cover property (@(posedge clk) disable iff (!rst_n) dec_op_r == OP_MOVE_FROM_HIGH_ROOT_CP0);
endmodule
`default_nettype wire

// ==== bench/exec_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module exec_sink
	import virt_dec_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic out_valid_r,
	input wire dec_op_t dec_op_r,
	input wire exc_t exc_r,
	output int bad_cnt
);
	// execute side: a faulting word must not carry an operation
	always @(posedge clk) begin
		if (!rst_n) begin
			bad_cnt <= 0;
		end else if (out_valid_r && exc_r !== EXC_NONE && dec_op_r !== OP_NONE) begin
			bad_cnt <= bad_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ==== bench/virt_opcode_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module virt_opcode_decoder_tb;
	import virt_dec_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, in_valid = 1'b0;
	logic [31:0] instr = 32'h0, r, w;
	logic kernel_mode = 1'b0, debug_mode = 1'b0, ops64_enabled = 1'b0, cp0_usable = 1'b0;
	logic module_present = 1'b1, wide_isa_impl = 1'b1, debug_insn_impl = 1'b0;
	logic out_valid_r, e_val;
	dec_op_t dec_op_r, e_op;
	exc_t exc_r, e_exc;
	int bad_cnt, error_cnt = 0, comparisons = 0, cycles = 0, i, s;

	virt_opcode_decoder i_virt_opcode_decoder(.clk(clk), .rst_n(rst_n), .ce(ce), .in_valid(in_valid),
		.instr(instr), .kernel_mode(kernel_mode), .debug_mode(debug_mode), .ops64_enabled(ops64_enabled),
		.cp0_usable(cp0_usable), .module_present(module_present), .wide_isa_impl(wide_isa_impl),
		.debug_insn_impl(debug_insn_impl), .out_valid_r(out_valid_r), .dec_op_r(dec_op_r), .exc_r(exc_r));
	exec_sink i_exec_sink(.clk(clk), .rst_n(rst_n), .out_valid_r(out_valid_r), .dec_op_r(dec_op_r),
		.exc_r(exc_r), .bad_cnt(bad_cnt));

	always #2.5 clk = ~clk;

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic cmp_bit(input string n, input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %b got %b", n, exp, got);
		end
	endtask

	task automatic cmp_op(input dec_op_t got, input dec_op_t exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED dec_op_r exp %h got %h", exp, got);
		end
	endtask

	task automatic cmp_exc(input exc_t got, input exc_t exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED exc_r exp %h got %h", exp, got);
		end
	endtask

	// reference decode of one accepted word
	task automatic model(input logic [31:0] x);
		logic mod_op;
		e_val = in_valid;
		e_op = OP_NONE;
		e_exc = EXC_NONE;
		mod_op = 1'b0;
		if (!in_valid) return;
		if (x[31:26] == 6'h00 && x[11:0] == 12'h17c) begin
			if (x[15:12] < 4'h6 || x[15:12] == 4'hc) begin
				e_op = (x[15:12] == 4'hc) ? OP_HYPERVISOR_CALL : dec_op_t'(13'h0002 << x[15:12]);
				mod_op = 1'b1;
			end else begin
				e_exc = EXC_RESERVED;
			end
		end else if (x[31:26] == 6'h00 && x[8:0] == 9'h0f4) begin
			e_op = dec_op_t'(13'h0100 << x[10:9]);
			mod_op = 1'b1;
		end else if (x[31:26] == 6'h16) begin
			if (!wide_isa_impl || x[2:0] == 3'h7 || !(kernel_mode || debug_mode || ops64_enabled)) begin
				e_exc = EXC_RESERVED;
			end else begin
				e_op = OP_SECOND_POOL;
			end
		end
		if (mod_op && !module_present) begin
			e_exc = EXC_RESERVED;
		end else if (mod_op && !kernel_mode && !debug_mode && !cp0_usable) begin
			e_exc = EXC_COP_UNUSABLE;
		end
		if (e_exc != EXC_NONE) begin
			e_op = OP_NONE;
		end
	endtask

	// one word per edge, checked one cycle later
	task automatic step(input logic [31:0] x);
		instr = x;
		if (!rst_n) begin
			e_val = 1'b0;
			e_op = OP_RESET;
			e_exc = EXC_RESET;
		end else if (ce) begin
			model(x);
		end
		@(posedge clk);
		#1;
		cmp_bit("out_valid_r", out_valid_r, e_val);
		cmp_op(dec_op_r, e_op);
		cmp_exc(exc_r, e_exc);
	endtask

	function automatic logic [31:0] word_of(input int k);
		logic [31:0] misc [6] = '{32'h0400017c, 32'h5c00017c, 32'h0000017d, 32'h0000013c, 32'h0000037c, 32'h000000f5};
		if (k < 16) return {16'h0000, k[3:0], 12'h17c};
		if (k < 24) return {20'h00000, k[2:0], 9'h0f4};
		if (k < 32) return {29'h0b000000, k[2:0]};
		return misc[k - 32];
	endfunction

	initial begin
		void'($urandom(32'h4d2f));
		repeat (5) @(posedge clk);
		#1;
		step(32'h0000017c);
		rst_n = 1'b1;
		in_valid = 1'b1;
		$display("test reset done");
		for (s = 0; s < 128; s++) begin
			{kernel_mode, debug_mode, ops64_enabled, cp0_usable, module_present, wide_isa_impl, debug_insn_impl} = s[6:0];
			for (i = 0; i < 38; i++) begin
				step(word_of(i));
			end
		end
		$display("test table sweep done");
		for (i = 0; i < 600; i++) begin
			r = $urandom;
			w = $urandom;
			{kernel_mode, debug_mode, ops64_enabled, cp0_usable, module_present, wide_isa_impl} = r[5:0];
			{debug_insn_impl, in_valid} = r[7:6];
			ce = r[10:8] != 3'h0;
			rst_n = r[15:11] != 5'h00;
			case (r[17:16])
				2'h0: w[11:0] = 12'h17c;
				2'h1: w[8:0] = 9'h0f4;
				2'h2: w[31:26] = 6'h16;
				default: ;
			endcase
			if (r[17:16] < 2'h2) begin
				w[31:26] = 6'h00;
			end
			step(w);
		end
		$display("test random traffic done");
		cmp_bit("sink_clean", bad_cnt == 0, 1'b1);
		final_report();
	end
endmodule
`default_nettype wire
